// *** logic/plc_pkg.sv ***
// Register map, reset values and widths of the parallel line controller
package plc_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADR_W  = 8;
   localparam int unsigned SEL_W  = DATA_W / 8;
   localparam int unsigned MAX_LINES = 32;

   typedef logic [ADR_W-1:0]  plc_adr_t;
   typedef logic [DATA_W-1:0] plc_word_t;
   typedef logic [SEL_W-1:0]  plc_sel_t;

   // Byte offsets of the register words
   localparam plc_adr_t OFF_OWNER_TAKE     = 8'h00;
   localparam plc_adr_t OFF_OWNER_RELEASE  = 8'h04;
   localparam plc_adr_t OFF_OWNER_STATUS   = 8'h08;
   localparam plc_adr_t OFF_DRIVE_SET      = 8'h10;
   localparam plc_adr_t OFF_DRIVE_CLEAR    = 8'h14;
   localparam plc_adr_t OFF_DRIVE_STATUS   = 8'h18;
   localparam plc_adr_t OFF_LEVEL_SET      = 8'h30;
   localparam plc_adr_t OFF_LEVEL_CLEAR    = 8'h34;
   localparam plc_adr_t OFF_LEVEL_VALUE    = 8'h38;
   localparam plc_adr_t OFF_PIN_LEVEL      = 8'h3C;
   localparam plc_adr_t OFF_EVENT_ENABLE   = 8'h40;
   localparam plc_adr_t OFF_EVENT_DISABLE  = 8'h44;
   localparam plc_adr_t OFF_EVENT_MASK     = 8'h48;
   localparam plc_adr_t OFF_EVENT_STATUS   = 8'h4C;
   localparam plc_adr_t OFF_PULLUP_ENABLE  = 8'h60;
   localparam plc_adr_t OFF_PULLUP_DISABLE = 8'h64;
   localparam plc_adr_t OFF_PULLUP_STATUS  = 8'h68;
   localparam plc_adr_t OFF_SELECT_FIRST   = 8'h70;
   localparam plc_adr_t OFF_SELECT_SECOND  = 8'h74;
   localparam plc_adr_t OFF_CHOICE_STATUS  = 8'h78;
   localparam plc_adr_t OFF_WMASK_SET      = 8'hA0;
   localparam plc_adr_t OFF_WMASK_CLEAR    = 8'hA4;
   localparam plc_adr_t OFF_WMASK_STATUS   = 8'hA8;

   // Reset values
   localparam plc_word_t RST_PULLUP_OFF = 32'h0000_0000;
   localparam plc_word_t RST_CHOICE     = 32'h0000_0000;
   localparam plc_word_t RST_DRIVE      = 32'h0000_0000;
   localparam plc_word_t RST_LEVEL      = 32'h0000_0000;
   localparam plc_word_t RST_WMASK      = 32'h0000_0000;
   localparam plc_word_t RST_EVENT      = 32'h0000_0000;
   localparam plc_word_t RST_OWNER      = 32'hFFFF_FFFF;
   localparam plc_word_t ALL_MUXED      = 32'hFFFF_FFFF;
   localparam plc_word_t READ_UNMAPPED  = 32'h0000_0000;
endpackage

// *** logic/plc_sample_if.sv ***
// Sampled pin levels and change pulses passed from the sampler to the controller
`timescale 1ns/10ps
interface plc_sample_if #(parameter int unsigned LINES = 32);
   logic [LINES-1:0] level;
   logic [LINES-1:0] change;
   logic [LINES-1:0] raw;

   modport src (output level, output change, output raw);
   modport dst (input level, input change, input raw);
endinterface

// *** logic/plc_pin_sampler.sv ***
// Pin synchroniser, gated level sampler and change detector
`timescale 1ns/10ps
module plc_pin_sampler #(
   parameter int unsigned LINES = 32
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   // Pins and clock gate
   input  wire logic [LINES-1:0] pad_in,
   input  wire logic             periph_clk_en,
   // Sampled view
   plc_sample_if.src             sif
);
   import plc_pkg::*;

   logic [LINES-1:0] sync1_q;
   logic [LINES-1:0] sync2_q;
   logic [LINES-1:0] level_q;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
      end
   end

   // Level is frozen while the clock gate is shut
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         level_q <= '0;
      else if (periph_clk_en)
         level_q <= sync2_q;
   end

   // Two successive samples differ; nothing is seen while gated
   assign sif.level  = level_q;
   assign sif.change = periph_clk_en ? (sync2_q ^ level_q) : '0;
   // Peripherals see the pin whatever the gate does
   assign sif.raw    = sync2_q;

   a_level_frozen : assert property (@(posedge clk_sys) disable iff (!arst_n)
      !periph_clk_en |=> $stable(level_q))
      else $error("pin level moved while the clock gate was shut");
endmodule

// *** logic/plc_line_ctrl.sv ***
// Parallel line controller: register file, pad multiplexer and change events
// Contract
// - Up to 32 lines, each at the same bit of every register.
// - Pull-up enable clears the off bit; disable sets it; 1 means off.
// - Pull-up off status resets to zero, all pull-ups on.
// - Pull-up writes act whatever the line's ownership or drive state.
// - Take/release writes set/clear ownership; 1 controller, 0 peripheral.
// - Lines without a peripheral ignore take/release and always read owned.
// - Ownership reset value is a per-product parameter, normally all ones.
// - First select clears the choice bit, second select sets it; 0 is A.
// - A/B choice steers only output paths; pin input goes to both.
// - Peripheral choice resets to zero, every line on peripheral A.
// - Choice writes act always; handing over needs select plus release.
// - Peripheral-owned line: chosen peripheral gives drive enable and level.
// - Drive enable set/clear writes; 0 input only, 1 controller drives.
// - Level set/clear writes change the driven output level register.
// - Drive and level writes act even while a peripheral owns the line.
// - Direct level write changes only bits whose write mask is 1.
// - Write mask set/clear writes; mask resets to zero.
// - All register writes act even with the peripheral clock gated.
// - Pin sampling and change detection only run while the clock gate is open.
// - Interrupt output only asserts while the clock gate is open.
// - Input path is untouched; peripherals see the pin without ownership.
// - Pin level status shows real levels; holds last sample when gated.
// - A change sets the event bit; masked events raise the interrupt.
// - Reading event status clears all reported pending bits.
// - Unimplemented line bits ignore writes and read zero.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module plc_line_ctrl #(
   parameter int unsigned        LINES       = 32,
   parameter plc_pkg::plc_word_t MUXED       = plc_pkg::ALL_MUXED,
   parameter plc_pkg::plc_word_t OWNER_RESET = plc_pkg::RST_OWNER
) (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 arst_n,
   // Wishbone classic slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire plc_pkg::plc_adr_t    wb_adr_i,
   input  wire plc_pkg::plc_sel_t    wb_sel_i,
   input  wire plc_pkg::plc_word_t   wb_dat_i,
   output plc_pkg::plc_word_t        wb_dat_o,
   output logic                      wb_ack_o,
   // Clock gate from power management
   input  wire logic                 periph_clk_en,
   // Pads
   input  wire logic [LINES-1:0]     pad_in,
   output logic [LINES-1:0]          pad_out,
   output logic [LINES-1:0]          pad_oe,
   output logic [LINES-1:0]          pad_pullup_off,
   // Peripheral functions A and B
   input  wire logic [LINES-1:0]     per_a_out,
   input  wire logic [LINES-1:0]     per_a_oe,
   input  wire logic [LINES-1:0]     per_b_out,
   input  wire logic [LINES-1:0]     per_b_oe,
   output logic [LINES-1:0]          per_in,
   // Change event interrupt
   output logic                      change_irq
);
   import plc_pkg::*;

   if (LINES < 1 || LINES > MAX_LINES)
   begin : g_bad_lines
      $error("LINES must lie between 1 and 32");
   end

   localparam logic [LINES-1:0] MUX_L   = MUXED[LINES-1:0];
   localparam logic [LINES-1:0] OWNR_L  = OWNER_RESET[LINES-1:0] | ~MUXED[LINES-1:0];

   plc_sample_if #(.LINES(LINES)) sif ();

   plc_pin_sampler #(.LINES(LINES)) u_sampler (
      .clk_sys       (clk_sys),
      .arst_n        (arst_n),
      .pad_in        (pad_in),
      .periph_clk_en (periph_clk_en),
      .sif           (sif)
   );

   logic [LINES-1:0] owner_q;
   logic [LINES-1:0] choice_q;
   logic [LINES-1:0] drive_q;
   logic [LINES-1:0] level_q;
   logic [LINES-1:0] wmask_q;
   logic [LINES-1:0] pullup_q;
   logic [LINES-1:0] emask_q;
   logic [LINES-1:0] event_q;
   logic [LINES-1:0] pad_out_q;
   logic [LINES-1:0] pad_oe_q;
   logic [LINES-1:0] per_in_q;
   logic             irq_q;
   logic             ack_q;
   plc_word_t        dat_q;
   plc_word_t        rdata;

   // Bus handshake: data captured on the request edge, acted on at the ack edge
   wire        req_new  = wb_cyc_i & wb_stb_i & ~ack_q;
   wire        req_done = wb_cyc_i & wb_stb_i & ack_q;
   wire        wr_take  = req_done & wb_we_i;
   wire        rd_take  = req_done & ~wb_we_i;
   plc_word_t  byte_en;
   genvar      gb;
   for (gb = 0; gb < SEL_W; gb++)
   begin : g_byte
      assign byte_en[gb*8 +: 8] = {8{wb_sel_i[gb]}};
   end
   // Bits above the implemented lines drop out here
   wire [LINES-1:0] wd = LINES'(wb_dat_i & byte_en);
   wire [LINES-1:0] be = LINES'(byte_en);

   wire [LINES-1:0] w_take   = (wr_take && wb_adr_i == OFF_OWNER_TAKE)     ? wd : '0;
   wire [LINES-1:0] w_rel    = (wr_take && wb_adr_i == OFF_OWNER_RELEASE)  ? wd : '0;
   wire [LINES-1:0] w_dset   = (wr_take && wb_adr_i == OFF_DRIVE_SET)      ? wd : '0;
   wire [LINES-1:0] w_dclr   = (wr_take && wb_adr_i == OFF_DRIVE_CLEAR)    ? wd : '0;
   wire [LINES-1:0] w_lset   = (wr_take && wb_adr_i == OFF_LEVEL_SET)      ? wd : '0;
   wire [LINES-1:0] w_lclr   = (wr_take && wb_adr_i == OFF_LEVEL_CLEAR)    ? wd : '0;
   wire             w_ldir   = wr_take && wb_adr_i == OFF_LEVEL_VALUE;
   wire [LINES-1:0] w_eset   = (wr_take && wb_adr_i == OFF_EVENT_ENABLE)   ? wd : '0;
   wire [LINES-1:0] w_eclr   = (wr_take && wb_adr_i == OFF_EVENT_DISABLE)  ? wd : '0;
   wire [LINES-1:0] w_puen   = (wr_take && wb_adr_i == OFF_PULLUP_ENABLE)  ? wd : '0;
   wire [LINES-1:0] w_pudis  = (wr_take && wb_adr_i == OFF_PULLUP_DISABLE) ? wd : '0;
   wire [LINES-1:0] w_sela   = (wr_take && wb_adr_i == OFF_SELECT_FIRST)   ? wd : '0;
   wire [LINES-1:0] w_selb   = (wr_take && wb_adr_i == OFF_SELECT_SECOND)  ? wd : '0;
   wire [LINES-1:0] w_mset   = (wr_take && wb_adr_i == OFF_WMASK_SET)      ? wd : '0;
   wire [LINES-1:0] w_mclr   = (wr_take && wb_adr_i == OFF_WMASK_CLEAR)    ? wd : '0;
   wire             rd_event = rd_take && wb_adr_i == OFF_EVENT_STATUS;

   // Only the bits the reader actually saw are cleared; later events survive
   wire [LINES-1:0] ev_clr   = rd_event ? LINES'(dat_q) : '0;

   // Next values; only event_d sees the clock gate, through the gated sif.change
   wire [LINES-1:0] owner_d  = ((owner_q | (w_take & MUX_L)) & ~(w_rel & MUX_L))
                               | ~MUX_L;
   wire [LINES-1:0] pullup_d = (pullup_q & ~w_puen) | w_pudis;
   wire [LINES-1:0] choice_d = (choice_q & ~w_sela) | w_selb;
   wire [LINES-1:0] drive_d  = (drive_q | w_dset) & ~w_dclr;
   wire [LINES-1:0] wmask_d  = (wmask_q | w_mset) & ~w_mclr;
   wire [LINES-1:0] dir_en   = w_ldir ? (wmask_q & be) : '0;
   wire [LINES-1:0] level_d  = (((level_q | w_lset) & ~w_lclr) & ~dir_en)
                               | (wd & dir_en);
   wire [LINES-1:0] emask_d  = (emask_q | w_eset) & ~w_eclr;
   wire [LINES-1:0] event_d  = (event_q & ~ev_clr) | sif.change;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         owner_q  <= OWNR_L;
         pullup_q <= RST_PULLUP_OFF[LINES-1:0];
         choice_q <= RST_CHOICE[LINES-1:0];
         drive_q  <= RST_DRIVE[LINES-1:0];
         level_q  <= RST_LEVEL[LINES-1:0];
         wmask_q  <= RST_WMASK[LINES-1:0];
         emask_q  <= RST_EVENT[LINES-1:0];
         event_q  <= RST_EVENT[LINES-1:0];
      end
      else
      begin
         owner_q  <= owner_d;
         pullup_q <= pullup_d;
         choice_q <= choice_d;
         drive_q  <= drive_d;
         level_q  <= level_d;
         wmask_q  <= wmask_d;
         emask_q  <= emask_d;
         event_q  <= event_d;
      end
   end

   // Pad multiplexer, one slice per line
   logic [LINES-1:0] oe_d;
   logic [LINES-1:0] out_d;
   genvar gi;
   for (gi = 0; gi < LINES; gi++)
   begin : g_pad
      wire per_oe  = choice_q[gi] ? per_b_oe[gi]  : per_a_oe[gi];
      wire per_out = choice_q[gi] ? per_b_out[gi] : per_a_out[gi];
      assign oe_d[gi]  = owner_q[gi] ? drive_q[gi] : per_oe;
      assign out_d[gi] = owner_q[gi] ? level_q[gi] : per_out;
   end

   // Registered pads cost one cycle but keep every output glitch free
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pad_oe_q  <= '0;
         pad_out_q <= '0;
         per_in_q  <= '0;
         irq_q     <= 1'b0;
      end
      else
      begin
         pad_oe_q  <= oe_d;
         pad_out_q <= out_d;
         // Raw synchronised pin, independent of ownership and gate
         per_in_q  <= sif.raw;
         irq_q     <= periph_clk_en & |(event_q & emask_q);
      end
   end

   // Read mux; unused upper bits read zero
   always_comb
   begin
      if (wb_adr_i == OFF_OWNER_STATUS)
         rdata = DATA_W'(owner_q);
      else if (wb_adr_i == OFF_DRIVE_STATUS)
         rdata = DATA_W'(drive_q);
      else if (wb_adr_i == OFF_LEVEL_VALUE)
         rdata = DATA_W'(level_q);
      else if (wb_adr_i == OFF_PIN_LEVEL)
         rdata = DATA_W'(sif.level);
      else if (wb_adr_i == OFF_EVENT_MASK)
         rdata = DATA_W'(emask_q);
      else if (wb_adr_i == OFF_EVENT_STATUS)
         rdata = DATA_W'(event_q);
      else if (wb_adr_i == OFF_PULLUP_STATUS)
         rdata = DATA_W'(pullup_q);
      else if (wb_adr_i == OFF_CHOICE_STATUS)
         rdata = DATA_W'(choice_q);
      else if (wb_adr_i == OFF_WMASK_STATUS)
         rdata = DATA_W'(wmask_q);
      else
         rdata = READ_UNMAPPED;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack_q <= 1'b0;
         dat_q <= READ_UNMAPPED;
      end
      else
      begin
         ack_q <= req_new;
         if (req_new)
            dat_q <= rdata;
      end
   end

   assign wb_ack_o       = ack_q;
   assign wb_dat_o       = dat_q;
   assign pad_oe         = pad_oe_q;
   assign pad_out        = pad_out_q;
   assign pad_pullup_off = pullup_q;
   assign per_in         = per_in_q;
   assign change_irq     = irq_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // Set and clear writes land at the ack edge, seen one edge later
   a_pullup_off_set : assert property (
      |w_pudis
      |=> (pullup_q & $past(w_pudis)) == $past(w_pudis))
      else $error("pull-up disable write did not set the off bit");
   a_pullup_on_clr : assert property (
      |w_puen
      |=> (pullup_q & $past(w_puen)) == '0)
      else $error("pull-up enable write did not clear the off bit");
   a_unmuxed_owned : assert property (
      (owner_q & ~MUX_L) == ~MUX_L)
      else $error("line without a peripheral lost controller ownership");
   a_owner_take : assert property (
      |(w_take & MUX_L)
      |=> (owner_q & $past(w_take & MUX_L)) == $past(w_take & MUX_L))
      else $error("take write did not give lines to the controller");
   a_owner_release : assert property (
      |(w_rel & MUX_L)
      |=> (owner_q & $past(w_rel & MUX_L)) == '0)
      else $error("release write did not hand lines over");

   a_choice_b_sel : assert property (
      |w_selb
      |=> (choice_q & $past(w_selb)) == $past(w_selb))
      else $error("second select write did not pick peripheral B");
   a_choice_a_sel : assert property (
      |w_sela
      |=> (choice_q & $past(w_sela)) == '0)
      else $error("first select write did not pick peripheral A");
   a_drive_set : assert property (
      |w_dset
      |=> (drive_q & $past(w_dset)) == $past(w_dset))
      else $error("drive set write was lost");
   a_drive_clr : assert property (
      |w_dclr
      |=> (drive_q & $past(w_dclr)) == '0)
      else $error("drive clear write was lost");

   a_level_set : assert property (
      |w_lset
      |=> (level_q & $past(w_lset)) == $past(w_lset))
      else $error("level set write was lost");
   a_level_clr : assert property (
      |w_lclr
      |=> (level_q & $past(w_lclr)) == '0)
      else $error("level clear write was lost");
   a_wmask_set : assert property (
      |w_mset
      |=> (wmask_q & $past(w_mset)) == $past(w_mset))
      else $error("write mask set write was lost");
   a_wmask_clr : assert property (
      |w_mclr
      |=> (wmask_q & $past(w_mclr)) == '0)
      else $error("write mask clear write was lost");
   a_direct_masked : assert property (
      w_ldir |=> ((level_q ^ $past(level_q)) & ~$past(wmask_q)) == '0)
      else $error("direct level write changed an unmasked bit");

   a_pad_owned_oe : assert property (
      owner_q[0] |=> pad_oe_q[0] == $past(drive_q[0]) && pad_out_q[0] == $past(level_q[0]))
      else $error("owned pad does not follow drive and level registers");
   a_pad_periph_b : assert property (
      |(~owner_q & choice_q)
      |=> ((pad_oe_q ^ $past(per_b_oe)) & $past(~owner_q & choice_q)) == '0)
      else $error("peripheral B does not steer its pad");
   a_unused_bits_zero : assert property (
      wb_ack_o |-> (dat_q >> LINES) == '0)
      else $error("read returned bits above the implemented lines");

   // A mask cleared in the same cycle as the change rightly stays silent
   a_irq_gate_off : assert property (
      !periph_clk_en |=> !irq_q)
      else $error("interrupt raised with the clock gate shut");
   a_irq_masked_evt : assert property (
      periph_clk_en && |(sif.change & emask_q & ~w_eclr) ##1 periph_clk_en |=> irq_q)
      else $error("masked change event failed to raise the interrupt");
   a_event_set : assert property (
      |sif.change
      |=> (event_q & $past(sif.change)) == $past(sif.change))
      else $error("pin change did not set its event bit");
   a_event_read_clr : assert property (
      rd_event |=> (event_q & $past(ev_clr) & ~$past(sif.change)) == '0)
      else $error("reported event bits survived the status read");
   a_ack_one_cycle : assert property (
      req_new |=> ack_q ##1 !ack_q)
      else $error("bus ack not a single cycle after the request");

   c_irq_raised  : cover property (!irq_q ##1 irq_q);
   c_direct_wr   : cover property (w_ldir && wmask_q != '0);
   c_event_read  : cover property (rd_event && event_q != '0);
   c_periph_b    : cover property (|(~owner_q & choice_q & pad_oe_q));
   c_owner_rel   : cover property (|(w_rel & MUX_L));
endmodule

// *** test/plc_far_model.sv ***
// Far-side model: pad wire levels and the two peripheral functions
`timescale 1ns/10ps
module plc_far_model #(
   parameter int unsigned LINES = 32,
   parameter logic [31:0] A_OUT = 32'h0000_0000,
   parameter logic [31:0] A_OE  = 32'h0000_0000,
   parameter logic [31:0] B_OUT = 32'h0000_0000,
   parameter logic [31:0] B_OE  = 32'h0000_0000
) (
   // Pad side of the controller
   input  wire logic [LINES-1:0] pad_out,
   input  wire logic [LINES-1:0] pad_oe,
   input  wire logic [LINES-1:0] pad_pullup_off,
   // Level that the board puts on released lines
   input  wire logic [LINES-1:0] ext_lvl,
   output logic [LINES-1:0]      pad_in,
   // Peripheral functions
   output logic [LINES-1:0]      per_a_out,
   output logic [LINES-1:0]      per_a_oe,
   output logic [LINES-1:0]      per_b_out,
   output logic [LINES-1:0]      per_b_oe
);
   // Driven pad wins; a released pad falls to the pull-up, else to the board
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~pad_pullup_off)
                 | (~pad_oe & pad_pullup_off & ext_lvl);
   // Peripherals drive fixed patterns so the steering shows at the pads
   assign per_a_out = A_OUT[LINES-1:0];
   assign per_a_oe  = A_OE[LINES-1:0];
   assign per_b_out = B_OUT[LINES-1:0];
   assign per_b_oe  = B_OE[LINES-1:0];
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the parallel line controller
`timescale 1ns/10ps
module tb_top;
   import plc_pkg::*;
   // Fewer lines than words so unused high bits get exercised
   localparam int unsigned L     = 28;
   localparam plc_word_t   LM    = 32'h0FFF_FFFF;
   localparam plc_word_t   MUX   = 32'h07FF_FFFF;
   localparam plc_word_t   ORST  = 32'hFFFF_FFFE;
   localparam plc_word_t   A_OUT = 32'h0400_0000;
   localparam plc_word_t   A_OE  = 32'h0500_0000;
   localparam plc_word_t   B_OUT = 32'h00A0_0000;
   localparam plc_word_t   B_OE  = 32'h00F0_0000;
   logic           clk_sys;
   logic           arst_n;
   logic           wb_cyc;
   logic           wb_stb;
   logic           wb_we;
   plc_adr_t       wb_adr;
   plc_sel_t       wb_sel;
   plc_word_t      wb_dat;
   plc_word_t      wb_dat_o;
   logic           wb_ack_o;
   logic           periph_clk_en;
   logic           change_irq;
   logic [L-1:0]   pad_in;
   logic [L-1:0]   pad_out;
   logic [L-1:0]   pad_oe;
   logic [L-1:0]   pad_pu_off;
   logic [L-1:0]   per_a_out;
   logic [L-1:0]   per_a_oe;
   logic [L-1:0]   per_b_out;
   logic [L-1:0]   per_b_oe;
   logic [L-1:0]   per_in;
   logic [L-1:0]   ext_lvl;
   plc_word_t      own_s;
   plc_word_t      ch_s;
   plc_word_t      drv_s;
   plc_word_t      lvl_s;
   plc_word_t      rd_v;
   plc_sel_t       sel_v;
   int             error_cnt;
   int             cmp_count;

   plc_line_ctrl #(.LINES(L), .MUXED(MUX), .OWNER_RESET(ORST)) plc_line_ctrl_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_clk_en(periph_clk_en),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_off(pad_pu_off),
      .per_a_out(per_a_out), .per_a_oe(per_a_oe), .per_b_out(per_b_out),
      .per_b_oe(per_b_oe), .per_in(per_in), .change_irq(change_irq));

   plc_far_model #(.LINES(L), .A_OUT(A_OUT), .A_OE(A_OE), .B_OUT(B_OUT), .B_OE(B_OE))
   plc_far_model_i (
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_off(pad_pu_off), .ext_lvl(ext_lvl),
      .pad_in(pad_in), .per_a_out(per_a_out), .per_a_oe(per_a_oe),
      .per_b_out(per_b_out), .per_b_oe(per_b_oe));

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input plc_word_t seen, input plc_word_t exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Classic single cycle; entered just after a rising edge
   task automatic wb_xfer(input logic we, input plc_adr_t a, input plc_word_t d,
                          output plc_word_t q);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= sel_v;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 20)
         error_cnt++;
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input plc_adr_t a, input plc_word_t d);
      plc_word_t q;
      wb_xfer(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input string name, input plc_adr_t a, input plc_word_t e);
      plc_word_t q;
      wb_xfer(1'b0, a, 32'h0000_0000, q);
      check(name, q, e);
   endtask

   // Pad drive expected from ownership, choice and controller registers
   function automatic plc_word_t exp_oe();
      return LM & ((own_s & drv_s) | (~own_s & ((ch_s & B_OE) | (~ch_s & A_OE))));
   endfunction

   function automatic plc_word_t exp_out();
      return LM & ((own_s & lvl_s) | (~own_s & ((ch_s & B_OUT) | (~ch_s & A_OUT))));
   endfunction

   initial
   begin
      repeat (3000) @(posedge clk_sys);
      error_cnt++;
      stop_test();
   end

   initial
   begin
      arst_n = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      sel_v = 4'hF;
      wb_dat = 32'h0000_0000;
      periph_clk_en = 1'b0;
      ext_lvl = '0;
      error_cnt = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      rd_chk("pu_stat", OFF_PULLUP_STATUS, RST_PULLUP_OFF);
      rd_chk("choice", OFF_CHOICE_STATUS, RST_CHOICE);
      rd_chk("owner", OFF_OWNER_STATUS, ORST & LM);
      rd_chk("wmask", OFF_WMASK_STATUS, RST_WMASK);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h0C, READ_UNMAPPED);
      $display("test reset done");
      wr(OFF_PULLUP_DISABLE, 32'hFFF0_00F0);
      rd_chk("pu_stat", OFF_PULLUP_STATUS, 32'h0FF0_00F0);
      wr(OFF_PULLUP_ENABLE, 32'h0000_00F0);
      rd_chk("pu_stat", OFF_PULLUP_STATUS, 32'h0FF0_0000);
      check("pu_pad", plc_word_t'(pad_pu_off), 32'h0FF0_0000);
      $display("test pullup done");
      wr(OFF_OWNER_RELEASE, 32'hFFFF_FFFF);
      rd_chk("owner", OFF_OWNER_STATUS, 32'h0800_0000);
      wr(OFF_OWNER_TAKE, 32'h0000_FFFF);
      wr(OFF_SELECT_SECOND, 32'h00FF_0000);
      rd_chk("owner", OFF_OWNER_STATUS, 32'h0800_FFFF);
      rd_chk("choice", OFF_CHOICE_STATUS, 32'h00FF_0000);
      wr(OFF_SELECT_FIRST, 32'h000F_0000);
      rd_chk("choice", OFF_CHOICE_STATUS, 32'h00F0_0000);
      $display("test ownership done");
      wr(OFF_DRIVE_SET, 32'hFFFF_FFFF);
      rd_chk("drive", OFF_DRIVE_STATUS, 32'h0FFF_FFFF);
      wr(OFF_DRIVE_CLEAR, 32'hFFFF_0000);
      rd_chk("drive", OFF_DRIVE_STATUS, 32'h0000_FFFF);
      wr(OFF_LEVEL_SET, 32'h00F0_00FF);
      wr(OFF_LEVEL_CLEAR, 32'h0000_000F);
      rd_chk("level", OFF_LEVEL_VALUE, 32'h00F0_00F0);
      wr(OFF_LEVEL_VALUE, 32'hFFFF_FFFF);
      rd_chk("level", OFF_LEVEL_VALUE, 32'h00F0_00F0);
      wr(OFF_WMASK_SET, 32'h0000_0F0F);
      rd_chk("wmask", OFF_WMASK_STATUS, 32'h0000_0F0F);
      wr(OFF_LEVEL_VALUE, 32'h0000_0A0A);
      rd_chk("level", OFF_LEVEL_VALUE, 32'h00F0_0AFA);
      wr(OFF_WMASK_CLEAR, 32'h0000_0F00);
      rd_chk("wmask", OFF_WMASK_STATUS, 32'h0000_000F);
      own_s = 32'h0800_FFFF;
      ch_s = 32'h00F0_0000;
      drv_s = 32'h0000_FFFF;
      lvl_s = 32'h00F0_0AFA;
      repeat (2) @(posedge clk_sys);
      check("pad_oe", plc_word_t'(pad_oe), exp_oe());
      check("pad_out", plc_word_t'(pad_out), exp_out());
      $display("test output done");
      // Gate opened before any pin read, as software must
      periph_clk_en <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd_chk("pin", OFF_PIN_LEVEL, plc_word_t'(pad_in));
      check("per_in", plc_word_t'(per_in), plc_word_t'(pad_in));
      wb_xfer(1'b0, OFF_EVENT_STATUS, 32'h0000_0000, rd_v);
      wr(OFF_EVENT_ENABLE, 32'h0800_0000);
      rd_chk("ev_mask", OFF_EVENT_MASK, 32'h0800_0000);
      ext_lvl[27] <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check("irq", {31'h0, change_irq}, 32'h1);
      rd_chk("ev_stat", OFF_EVENT_STATUS, 32'h0800_0000);
      rd_chk("ev_stat", OFF_EVENT_STATUS, 32'h0000_0000);
      check("irq", {31'h0, change_irq}, 32'h0);
      $display("test events done");
      periph_clk_en <= 1'b0;
      ext_lvl[27] <= 1'b0;
      repeat (8) @(posedge clk_sys);
      check("irq", {31'h0, change_irq}, 32'h0);
      rd_chk("pin", OFF_PIN_LEVEL, plc_word_t'(pad_in) | 32'h0800_0000);
      wr(OFF_DRIVE_SET, 32'h0800_0000);
      rd_chk("drive", OFF_DRIVE_STATUS, 32'h0800_FFFF);
      periph_clk_en <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check("irq", {31'h0, change_irq}, 32'h1);
      rd_chk("ev_stat", OFF_EVENT_STATUS, 32'h0800_0000);
      $display("test clock gate done");
      wr(OFF_EVENT_DISABLE, 32'hFFFF_FFFF);
      rd_chk("ev_mask", OFF_EVENT_MASK, 32'h0000_0000);
      sel_v = 4'h1;
      wr(OFF_WMASK_SET, 32'hFFFF_FFFF);
      rd_chk("wmask", OFF_WMASK_STATUS, 32'h0000_00FF);
      $display("test lanes done");
      stop_test();
   end
endmodule
